//--- rtl/jbs_pkg.sv
package jbs_pkg;

	localparam int JBS_BYTE_W = 8;
	localparam int JBS_BITCNT_W = 3;
	localparam logic [2:0] JBS_LAST_BIT = 3'h7;
	localparam logic [7:0] JBS_BYTE_RST = 8'h00;

	// remote reset pulse: one second at 250 MHz
	localparam int JBS_RST_TIME_MS = 1000;
	localparam int JBS_CLK_KHZ = 250000;
	localparam int unsigned JBS_RST_CYC = JBS_RST_TIME_MS * JBS_CLK_KHZ;
	localparam int JBS_RST_CNT_W = 28;

	// free counter whose top bit stands for the system clock level
	localparam int JBS_DIV_W = 4;

	localparam int JBS_SIM_PORT_DEF = 50000;
	localparam int JBS_FIFO_DEPTH = 2;

	typedef enum logic [2:0] {
		JBS_CMD_IDLE,
		JBS_CMD_SEND,
		JBS_CMD_RECV,
		JBS_CMD_LOOP,
		JBS_CMD_RESET,
		JBS_CMD_SMP_CLK,
		JBS_CMD_SMP_RST,
		JBS_CMD_SENSE
	} jbs_cmd_e;

	typedef struct packed {
		logic valid;
		logic [JBS_BYTE_W-1:0] data;
	} jbs_beat_s;

endpackage : jbs_pkg

//--- rtl/jbs_fifo2.sv
`timescale 1ns/1ps
module jbs_fifo2 (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire jbs_pkg::jbs_beat_s i_in,
	output logic o_in_ready,
	output jbs_pkg::jbs_beat_s o_out,
	input wire logic i_out_ready
);
	typedef struct packed {
		logic [jbs_pkg::JBS_FIFO_DEPTH-1:0][jbs_pkg::JBS_BYTE_W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
		logic not_full;
	} jbs_fifo_st_s;

	jbs_fifo_st_s st_ff;
	jbs_fifo_st_s nxt_st;
	logic push;
	logic pop;

	always_comb begin
		nxt_st = st_ff;
		push = i_in.valid && st_ff.not_full;
		pop = (st_ff.cnt != 2'h0) && i_out_ready;
		if (push) begin
			nxt_st.mem[st_ff.wp] = i_in.data;
			nxt_st.wp = ~st_ff.wp;
		end
		if (pop) begin
			nxt_st.rp = ~st_ff.rp;
		end
		nxt_st.cnt = 2'(st_ff.cnt + {1'b0, push} - {1'b0, pop});
		nxt_st.not_full = (nxt_st.cnt != 2'h2);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
			st_ff.not_full <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_in_ready = st_ff.not_full;
	assign o_out.valid = (st_ff.cnt != 2'h0);
	assign o_out.data = st_ff.mem[st_ff.rp];

	a_fifo_no_overflow: assert property (@(posedge i_clk) disable iff (i_rst)
		(st_ff.cnt == 2'h2) |-> !o_in_ready)
		else $error("buffer full but still ready");
	a_fifo_keeps_word: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_out.valid && !i_out_ready) |=> (o_out.valid && $stable(o_out.data)))
		else $error("stalled word lost");
endmodule : jbs_fifo2

//--- rtl/jbs_bridge.sv
`timescale 1ns/1ps
// Function
// - only the sink port takes back-pressure; source bytes are always taken.
// - each beat on either stream port carries exactly one 8-bit byte.
// - link bits are gathered into bytes, and bytes shifted out bit by bit.
// - send command puts link bytes on the source port in shift order.
// - receive command returns sink bytes to the host in accepted order.
// - loop check returns each link byte through an internal holding register.
// - reset command holds the reset request output high at least one second.
// - clock sample command captures the system clock level once for the host.
// - reset sample command captures the active-low reset input once.
// - clock sense sets a flag on each change, either edge, of the divided clock, for the host to read.
// - simulation port number 1 to 65535, default 50000, no hardware effect.
module jbs_bridge #(
	parameter int unsigned P_RST_CYC = jbs_pkg::JBS_RST_CYC,
	parameter int unsigned P_SIM_PORT = jbs_pkg::JBS_SIM_PORT_DEF
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_sys_rst_n,
	output jbs_pkg::jbs_beat_s o_src,
	input wire jbs_pkg::jbs_beat_s i_snk,
	output logic o_snk_ready,
	output logic o_resetrequest,
	input wire logic i_tck,
	input wire logic i_tdi,
	input wire logic i_shift,
	input wire logic i_update,
	input wire jbs_pkg::jbs_cmd_e i_cmd,
	output logic o_tdo
);
	typedef struct packed {
		jbs_pkg::jbs_beat_s src;
		logic tx_s1;
		logic tx_s2;
		logic tx_seen;
		logic rx_req;
		logic [jbs_pkg::JBS_BYTE_W-1:0] rx_data;
		logic rxack_s1;
		logic rxack_s2;
		logic rst_s1;
		logic rst_s2;
		logic rst_seen;
		logic [jbs_pkg::JBS_RST_CNT_W-1:0] rst_cnt;
		logic rst_out;
		logic [jbs_pkg::JBS_DIV_W-1:0] div;
	} jbs_sys_st_s;

	typedef struct packed {
		logic [jbs_pkg::JBS_BYTE_W-1:0] sr;
		logic [jbs_pkg::JBS_BITCNT_W-1:0] cnt;
		logic tdo;
		logic [jbs_pkg::JBS_BYTE_W-1:0] tx_data;
		logic tx_req;
		logic txack_s1;
		logic txack_s2;
		logic rx_s1;
		logic rx_s2;
		logic rx_ack;
		logic rst_tgl;
		logic clk_s1;
		logic clk_s2;
		logic clk_prev;
		logic rstn_s1;
		logic rstn_s2;
		logic flag;
	} jbs_lnk_st_s;

	localparam logic [jbs_pkg::JBS_RST_CNT_W-1:0] RST_LOAD =
		jbs_pkg::JBS_RST_CNT_W'(P_RST_CYC);

	jbs_sys_st_s sys_ff;
	jbs_sys_st_s nxt_sys;
	jbs_lnk_st_s lnk_ff;
	jbs_lnk_st_s nxt_lnk;
	jbs_pkg::jbs_beat_s fifo_out;
	logic fifo_in_ready;
	logic rx_slot_free;
	logic rx_avail;
	logic rx_load;

	// sink bytes wait here while the link side is slow to drain them
	jbs_fifo2 u_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_in(i_snk),
		.o_in_ready(fifo_in_ready),
		.o_out(fifo_out),
		.i_out_ready(rx_slot_free)
	);

	// ---------------- system clock domain ----------------
	// slot is free once the link side has acknowledged the last byte
	assign rx_slot_free = (sys_ff.rx_req == sys_ff.rxack_s2);

	always_comb begin
		nxt_sys = sys_ff;
		nxt_sys.src.valid = 1'b0;
		nxt_sys.tx_s1 = lnk_ff.tx_req;
		nxt_sys.tx_s2 = sys_ff.tx_s1;
		nxt_sys.rxack_s1 = lnk_ff.rx_ack;
		nxt_sys.rxack_s2 = sys_ff.rxack_s1;
		nxt_sys.rst_s1 = lnk_ff.rst_tgl;
		nxt_sys.rst_s2 = sys_ff.rst_s1;
		nxt_sys.div = jbs_pkg::JBS_DIV_W'(sys_ff.div + 1'b1);
		// tx_data is held still by the link side until acknowledged
		if (sys_ff.tx_s2 != sys_ff.tx_seen) begin
			nxt_sys.src.valid = 1'b1;
			nxt_sys.src.data = lnk_ff.tx_data;
			nxt_sys.tx_seen = sys_ff.tx_s2;
		end
		if (fifo_out.valid && rx_slot_free) begin
			nxt_sys.rx_data = fifo_out.data;
			nxt_sys.rx_req = ~sys_ff.rx_req;
		end
		if (sys_ff.rst_s2 != sys_ff.rst_seen) begin
			nxt_sys.rst_seen = sys_ff.rst_s2;
			nxt_sys.rst_cnt = RST_LOAD;
		end else if (sys_ff.rst_cnt != '0) begin
			nxt_sys.rst_cnt = jbs_pkg::JBS_RST_CNT_W'(sys_ff.rst_cnt - 1'b1);
		end
		nxt_sys.rst_out = (nxt_sys.rst_cnt != '0);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sys_ff <= '0;
		end else begin
			sys_ff <= nxt_sys;
		end
	end

	// ---------------- link clock domain ----------------
	assign rx_avail = (lnk_ff.rx_s2 != lnk_ff.rx_ack);
	assign rx_load = i_shift && (lnk_ff.cnt == '0) &&
		(i_cmd == jbs_pkg::JBS_CMD_RECV) && rx_avail;

	always_comb begin
		nxt_lnk = lnk_ff;
		nxt_lnk.txack_s1 = sys_ff.tx_seen;
		nxt_lnk.txack_s2 = lnk_ff.txack_s1;
		nxt_lnk.rx_s1 = sys_ff.rx_req;
		nxt_lnk.rx_s2 = lnk_ff.rx_s1;
		nxt_lnk.clk_s1 = sys_ff.div[jbs_pkg::JBS_DIV_W-1];
		nxt_lnk.clk_s2 = lnk_ff.clk_s1;
		nxt_lnk.clk_prev = lnk_ff.clk_s2;
		nxt_lnk.rstn_s1 = i_sys_rst_n;
		nxt_lnk.rstn_s2 = lnk_ff.rstn_s1;
		// a change of the divided clock means the system clock rose
		if (lnk_ff.clk_s2 != lnk_ff.clk_prev) begin
			nxt_lnk.flag = 1'b1;
		end
		if (i_shift) begin
			nxt_lnk.cnt = jbs_pkg::JBS_BITCNT_W'(lnk_ff.cnt + 1'b1);
			if (rx_load) begin
				// rx_data stands still until rx_ack toggles back
				nxt_lnk.tdo = sys_ff.rx_data[0];
				nxt_lnk.sr = {i_tdi, sys_ff.rx_data[7:1]};
				nxt_lnk.rx_ack = ~lnk_ff.rx_ack;
			end else begin
				nxt_lnk.tdo = lnk_ff.sr[0];
				nxt_lnk.sr = {i_tdi, lnk_ff.sr[7:1]};
			end
			// a byte arriving before the last is taken is dropped
			if ((lnk_ff.cnt == jbs_pkg::JBS_LAST_BIT) &&
				(i_cmd == jbs_pkg::JBS_CMD_SEND) &&
				(lnk_ff.txack_s2 == lnk_ff.tx_req)) begin
				nxt_lnk.tx_data = {i_tdi, lnk_ff.sr[7:1]};
				nxt_lnk.tx_req = ~lnk_ff.tx_req;
			end
		end else if (i_update) begin
			nxt_lnk.cnt = '0;
			case (i_cmd)
			jbs_pkg::JBS_CMD_RESET: begin
				nxt_lnk.rst_tgl = ~lnk_ff.rst_tgl;
			end
			jbs_pkg::JBS_CMD_SMP_CLK: begin
				nxt_lnk.sr = {7'h00, lnk_ff.clk_s2};
			end
			jbs_pkg::JBS_CMD_SMP_RST: begin
				nxt_lnk.sr = {7'h00, lnk_ff.rstn_s2};
			end
			jbs_pkg::JBS_CMD_SENSE: begin
				nxt_lnk.sr = {7'h00, lnk_ff.flag};
				// a rise seen in this very cycle keeps the flag set
				nxt_lnk.flag = (lnk_ff.clk_s2 != lnk_ff.clk_prev);
			end
			default: begin
				nxt_lnk.sr = lnk_ff.sr;
			end
			endcase
		end
	end

	always_ff @(posedge i_tck or posedge i_rst) begin
		if (i_rst) begin
			lnk_ff <= '0;
		end else begin
			lnk_ff <= nxt_lnk;
		end
	end

	assign o_src = sys_ff.src;
	assign o_snk_ready = fifo_in_ready;
	assign o_resetrequest = sys_ff.rst_out;
	assign o_tdo = lnk_ff.tdo;

	// ---------------- checks ----------------
	sequence s_tx_event;
		sys_ff.tx_s2 != sys_ff.tx_seen;
	endsequence

	sequence s_tx_beat;
		o_src.valid ##1 !o_src.valid;
	endsequence

	a_src_byte_order: assert property (@(posedge i_clk) disable iff (i_rst)
		s_tx_event |=> (o_src.valid && o_src.data == $past(lnk_ff.tx_data)))
		else $error("source byte does not match link byte");
	a_src_one_beat: assert property (@(posedge i_clk) disable iff (i_rst)
		s_tx_event |=> s_tx_beat)
		else $error("source beat not a single cycle");
	a_rst_req_start: assert property (@(posedge i_clk) disable iff (i_rst)
		(sys_ff.rst_s2 != sys_ff.rst_seen) |=>
			(o_resetrequest && sys_ff.rst_cnt == RST_LOAD))
		else $error("reset request not started");
	a_rst_req_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		(sys_ff.rst_cnt > 28'h1) |=> o_resetrequest)
		else $error("reset request dropped early");
	a_rx_data_held: assert property (@(posedge i_clk) disable iff (i_rst)
		(!rx_slot_free) |=> $stable(sys_ff.rx_data))
		else $error("receive word changed while pending");
	a_byte_wrap: assert property (@(posedge i_tck) disable iff (i_rst)
		(i_shift && lnk_ff.cnt == jbs_pkg::JBS_LAST_BIT) |=>
			(lnk_ff.cnt == 3'h0))
		else $error("bit count did not wrap at byte end");
	a_loop_return: assert property (@(posedge i_tck) disable iff (i_rst)
		(i_shift && !rx_load) |=> (o_tdo == $past(lnk_ff.sr[0])))
		else $error("loop bit not returned from holding register");
	a_smp_clk_once: assert property (@(posedge i_tck) disable iff (i_rst)
		(i_update && !i_shift && i_cmd == jbs_pkg::JBS_CMD_SMP_CLK) |=>
			(lnk_ff.sr == {7'h00, $past(lnk_ff.clk_s2)}))
		else $error("clock level not captured");
	a_smp_rst_once: assert property (@(posedge i_tck) disable iff (i_rst)
		(i_update && !i_shift && i_cmd == jbs_pkg::JBS_CMD_SMP_RST) |=>
			(lnk_ff.sr == {7'h00, $past(lnk_ff.rstn_s2)}))
		else $error("reset level not captured");
	a_sense_flag_set: assert property (@(posedge i_tck) disable iff (i_rst)
		(lnk_ff.clk_s2 != lnk_ff.clk_prev) |=> lnk_ff.flag)
		else $error("clock sense flag not set");
endmodule : jbs_bridge

//--- testbench/jbs_host_model.sv
`timescale 1ns/1ps
module jbs_host_model (
	output logic o_tck,
	output logic o_tdi,
	output logic o_shift,
	output logic o_update,
	output jbs_pkg::jbs_cmd_e o_cmd,
	input wire logic i_tdo
);
	localparam realtime HALF = 62.5;
	initial begin
		o_tck = 1'b0;
		o_tdi = 1'b0;
		o_shift = 1'b0;
		o_update = 1'b0;
		o_cmd = jbs_pkg::JBS_CMD_IDLE;
	end
	// link clock rests low between frames
	task pulse;
		#HALF o_tck = 1'b1;
		#HALF o_tck = 1'b0;
	endtask : pulse
	task set_cmd(input jbs_pkg::jbs_cmd_e c);
		o_cmd = c;
		o_update = 1'b1;
		pulse();
		o_update = 1'b0;
	endtask : set_cmd
	// lsb first, tdo read after the edge that moves it
	task xfer(input logic [7:0] d, output logic [7:0] q);
		for (int i = 0; i < 8; i++) begin
			o_tdi = d[i];
			o_shift = 1'b1;
			pulse();
			q[i] = i_tdo;
		end
		o_shift = 1'b0;
		// released line must not keep the last bit
		o_tdi = ~o_tdi;
	endtask : xfer
endmodule : jbs_host_model

//--- testbench/jbs_bridge_tb.sv
`timescale 1ns/1ps
module jbs_bridge_tb;
	localparam int unsigned RST_CYC = 20;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_sys_rst_n = 1'b1;
	jbs_pkg::jbs_beat_s o_src;
	jbs_pkg::jbs_beat_s i_snk = '0;
	logic o_snk_ready, o_resetrequest, o_tdo;
	logic tck, tdi, shift, update;
	jbs_pkg::jbs_cmd_e cmd;
	int n_errors = 0;
	int comparisons = 0;
	int n;
	logic [7:0] got;
	logic [7:0] srcq[$];
	// byte shifted in beside the byte expected at the source
	logic [15:0] rows[4] = '{16'h0101, 16'h8080, 16'hA5A5, 16'h3C3C};
	logic [7:0] snk_b[3] = '{8'h11, 8'hE2, 8'h7F};

	always #2 i_clk = ~i_clk;

	jbs_bridge #(.P_RST_CYC(RST_CYC)) jbs_bridge_inst (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_sys_rst_n(i_sys_rst_n),
		.o_src(o_src),
		.i_snk(i_snk),
		.o_snk_ready(o_snk_ready),
		.o_resetrequest(o_resetrequest),
		.i_tck(tck),
		.i_tdi(tdi),
		.i_shift(shift),
		.i_update(update),
		.i_cmd(cmd),
		.o_tdo(o_tdo)
	);
	jbs_host_model jbs_host_model_inst (
		.o_tck(tck),
		.o_tdi(tdi),
		.o_shift(shift),
		.o_update(update),
		.o_cmd(cmd),
		.i_tdo(o_tdo)
	);

	// source has no ready, so every valid cycle is a byte;
	// looked at mid-cycle, away from the edge that launches it
	always @(negedge i_clk) begin
		if (o_src.valid === 1'b1)
			srcq.push_back(o_src.data);
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task report_and_stop;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task push(input logic [7:0] b);
		logic acc;
		@(negedge i_clk);
		i_snk = {1'b1, b};
		do begin
			acc = o_snk_ready;
			@(negedge i_clk);
		end while (acc !== 1'b1);
		i_snk.valid = 1'b0;
	endtask : push
	// synchroniser in the link domain needs link edges
	task sample(input jbs_pkg::jbs_cmd_e c);
		repeat (3) jbs_host_model_inst.pulse();
		jbs_host_model_inst.set_cmd(c);
		jbs_host_model_inst.xfer(8'h00, got);
	endtask : sample

	initial begin
		#100000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		repeat (10) @(negedge i_clk);
		chk({7'h00, o_src.valid}, 8'h00);
		chk({7'h00, o_snk_ready}, 8'h01);
		chk({6'h00, o_resetrequest, o_tdo}, 8'h00);
		i_rst = 1'b0;
		repeat (3) @(negedge i_clk);
		$display("test reset done");
		jbs_host_model_inst.set_cmd(jbs_pkg::JBS_CMD_SEND);
		foreach (rows[i]) begin
			jbs_host_model_inst.xfer(rows[i][15:8], got);
			repeat (10) @(negedge i_clk);
			chk(8'(srcq.size()), 8'h01);
			chk(srcq.pop_front(), rows[i][7:0]);
		end
		$display("test send done");
		jbs_host_model_inst.set_cmd(jbs_pkg::JBS_CMD_LOOP);
		jbs_host_model_inst.xfer(8'h5A, got);
		jbs_host_model_inst.xfer(8'hC3, got);
		chk(got, 8'h5A);
		$display("test loop done");
		// link is idle, so the buffer fills and refuses
		foreach (snk_b[i]) push(snk_b[i]);
		repeat (6) @(negedge i_clk);
		chk({7'h00, o_snk_ready}, 8'h00);
		jbs_host_model_inst.set_cmd(jbs_pkg::JBS_CMD_RECV);
		// pending flag needs link edges to cross before the first byte
		repeat (3) jbs_host_model_inst.pulse();
		foreach (snk_b[i]) begin
			jbs_host_model_inst.xfer(8'h00, got);
			chk(got, snk_b[i]);
		end
		repeat (6) @(negedge i_clk);
		chk({7'h00, o_snk_ready}, 8'h01);
		$display("test receive done");
		n = 0;
		fork
			jbs_host_model_inst.set_cmd(jbs_pkg::JBS_CMD_RESET);
			begin
				for (int k = 0; k < 100 && o_resetrequest !== 1'b1; k++)
					@(negedge i_clk);
				while (o_resetrequest === 1'b1 && n < 1000) begin
					n++;
					@(negedge i_clk);
				end
			end
		join
		chk(8'(n), 8'(RST_CYC));
		$display("test reset request done");
		i_sys_rst_n = 1'b0;
		sample(jbs_pkg::JBS_CMD_SMP_RST);
		chk(got, 8'h00);
		i_sys_rst_n = 1'b1;
		sample(jbs_pkg::JBS_CMD_SMP_RST);
		chk(got, 8'h01);
		sample(jbs_pkg::JBS_CMD_SMP_CLK);
		chk(got & 8'hFE, 8'h00);
		sample(jbs_pkg::JBS_CMD_SENSE);
		sample(jbs_pkg::JBS_CMD_SENSE);
		chk(got, 8'h01);
		chk(8'(srcq.size()), 8'h00);
		$display("test debug done");
		report_and_stop();
	end
endmodule : jbs_bridge_tb
